// *** design/psc_top.sv ***
// Purpose: power-save mode sequencing, low-power wake, CPU slowdown and peripheral clock gating
// Assumes: core_clk is the always-on control clock; the gated system clock is sys_clk_en
// Notes: registers reached over AHB-Lite, zero wait states, always OKAY
//
// Function
// - interrupts during power-save entry wait until entry ends, then wake the device
// - wake pin dropping below threshold while discharging ends Sleep, resumes execution
// - wake event sets bit 0 of interrupt flag register five
// - wake_control bit 15 enables the wake module, reset value 0
// - wake_control bit 8 enables the discharge current sink, reset value 0
// - wake_control bit 13 stops the wake module during Idle
// - unimplemented wake_control bits read zero and ignore writes
// - slowdown keeps system and peripheral clocks, lowers only CPU rate
// - slowed CPU clock stays aligned with peripheral clock domain
// - clock divider bit 11 turns CPU slowdown on or off
// - bits 14 to 12 choose ratio 1:1 to 1:128, default 1:1
// - bit 15 set lets an interrupt end slowdown; clear leaves slowdown alone
// - module-disable bit gates every clock of that peripheral
// - disabled module registers ignore writes and read invalid
// - cleared module-enable stops function, registers stay accessible
// - peripherals run in Idle unless their stop-in-idle bit is set
// - Sleep stops system clock and code; Idle stops CPU only
// - Sleep or Idle ends on enabled interrupt, watchdog time-out or reset
`timescale 1ns/100ps
`default_nettype none
module psc_top
  import psc_pkg::*;
#(
  parameter int NUM_PERIPH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // CPU core
  input wire logic power_save_req,
  input wire logic power_save_sleep,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  output logic irq_to_cpu,
  output logic wake_pulse,
  output logic cpu_clk_en,
  output logic in_sleep,
  output logic in_idle,
  // system and peripheral clocks
  output logic sys_clk_en,
  output logic [NUM_PERIPH-1:0] periph_clk_en,
  output logic [NUM_PERIPH-1:0] periph_func_en,
  output logic [NUM_PERIPH-1:0] periph_reg_en,
  // wake pin pad
  input wire logic wake_pin_low,
  output logic wake_sink_en,
  output logic wake_comp_en
);

  import psc_pkg::*;

  // state and registers
  psc_state_t state_q, state_d;
  psc_ahb_cap_t cap_q;
  logic [15:0] wake_ctl_q;
  logic [15:0] div_ctl_q;
  logic flag_wake_q;
  logic [NUM_PERIPH-1:0] mod_dis_q;
  logic [NUM_PERIPH-1:0] mod_en_q;
  logic [NUM_PERIPH-1:0] mod_idl_q;
  logic irq_held_q;
  logic [PSC_DOZE_CNT_W-1:0] doze_cnt_q;
  logic pin_low_prev_q;

  // combinational helpers
  logic pin_low_s;
  logic wake_active;
  logic wake_event;
  logic wake_any;
  logic bus_wr;
  logic [15:0] wdata16;
  logic [PSC_RATIO_W-1:0] ratio;
  logic [PSC_DOZE_CNT_W-1:0] doze_limit;
  logic doze_on;
  logic ret_int_clear;
  logic is_sleep;
  logic is_idle;
  logic [31:0] rd_mux;

  // address phase is valid only on a selected NONSEQ or SEQ with the bus ready
  logic addr_phase;
  assign addr_phase = hsel && hready && (htrans == PSC_HTRANS_NONSEQ || htrans == PSC_HTRANS_SEQ);

  // write happens in the data phase of a captured write
  assign bus_wr = cap_q.vld && cap_q.wr;
  assign wdata16 = hwdata[15:0];

  // register the address phase for use in the data phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cap_q <= '0;
    end else if (hready) begin
      cap_q.vld <= addr_phase;
      cap_q.wr <= hwrite;
      cap_q.addr <= haddr[PSC_ADDR_W-1:0];
    end
  end

  // zero wait states, only OKAY responses
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= PSC_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= PSC_HRESP_OKAY;
    end
  end

  // read mux; unmapped offsets and unimplemented bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[PSC_ADDR_W-1:0] == PSC_OFS_WAKE_CONTROL) begin
      rd_mux[15:0] = wake_ctl_q & PSC_WAKE_WR_MASK;
    end else if (haddr[PSC_ADDR_W-1:0] == PSC_OFS_CLOCK_DIVIDER) begin
      rd_mux[15:0] = div_ctl_q & PSC_DIV_WR_MASK;
    end else if (haddr[PSC_ADDR_W-1:0] == PSC_OFS_FLAG_FIVE) begin
      rd_mux[PSC_FLAG_WAKE_BIT] = flag_wake_q;
    end else if (haddr[PSC_ADDR_W-1:0] == PSC_OFS_MODULE_DISABLE) begin
      rd_mux[NUM_PERIPH-1:0] = mod_dis_q;
    end else if (haddr[PSC_ADDR_W-1:0] == PSC_OFS_MODULE_ENABLE) begin
      rd_mux[NUM_PERIPH-1:0] = mod_en_q;
    end else if (haddr[PSC_ADDR_W-1:0] == PSC_OFS_MODULE_IDLE_STOP) begin
      rd_mux[NUM_PERIPH-1:0] = mod_idl_q;
    end else if (haddr[PSC_ADDR_W-1:0] == PSC_OFS_POWER_STATUS) begin
      rd_mux[PSC_STAT_SLEEP_BIT] = is_sleep;
      rd_mux[PSC_STAT_IDLE_BIT] = is_idle;
      rd_mux[PSC_STAT_ENTER_BIT] = (state_q == PSC_ST_ENTER);
      rd_mux[PSC_STAT_CPU_CLK_BIT] = cpu_clk_en;
    end
  end

  // read data sampled at the address-phase edge, stands through the data phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // wake control register: only enable, stop-in-idle and sink bits are stored
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_ctl_q <= PSC_WAKE_RESET;
    end else if (bus_wr && cap_q.addr == PSC_OFS_WAKE_CONTROL) begin
      wake_ctl_q <= wdata16 & PSC_WAKE_WR_MASK;
    end
  end

  // clock divider register; an interrupt may drop the slowdown enable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_ctl_q <= PSC_DIV_RESET;
    end else begin
      if (bus_wr && cap_q.addr == PSC_OFS_CLOCK_DIVIDER) begin
        div_ctl_q <= wdata16 & PSC_DIV_WR_MASK;
      end
      // hardware clear wins so an interrupt with return-on-interrupt set restores full speed
      if (ret_int_clear) begin
        div_ctl_q[PSC_DIV_SLOW_EN_BIT] <= 1'b0;
      end
    end
  end

  // peripheral disable, enable and stop-in-idle bits
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mod_dis_q <= '0;
      mod_en_q <= '0;
      mod_idl_q <= '0;
    end else if (bus_wr) begin
      if (cap_q.addr == PSC_OFS_MODULE_DISABLE) begin
        mod_dis_q <= hwdata[NUM_PERIPH-1:0];
      end else if (cap_q.addr == PSC_OFS_MODULE_ENABLE) begin
        mod_en_q <= hwdata[NUM_PERIPH-1:0];
      end else if (cap_q.addr == PSC_OFS_MODULE_IDLE_STOP) begin
        mod_idl_q <= hwdata[NUM_PERIPH-1:0];
      end
    end
  end

  // wake flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_wake_q <= 1'b0;
    end else if (wake_event) begin
      flag_wake_q <= 1'b1;
    end else if (bus_wr && cap_q.addr == PSC_OFS_FLAG_FIVE) begin
      flag_wake_q <= hwdata[PSC_FLAG_WAKE_BIT];
    end
  end

  // pad comparator output crosses into core_clk through two flops
  psc_sync2 #(
    .WIDTH(1)
  ) u_pin_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .din(wake_pin_low),
    .dout(pin_low_s)
  );

  // remember the synchronised level for edge detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_low_prev_q <= 1'b0;
    end else begin
      pin_low_prev_q <= pin_low_s;
    end
  end

  // decoded power state
  assign is_sleep = (state_q == PSC_ST_SLEEP);
  assign is_idle = (state_q == PSC_ST_IDLE);

  // wake module runs when enabled, except in Idle with stop-in-idle set
  assign wake_active = wake_ctl_q[PSC_WAKE_EN_BIT]
                     && !(is_idle && wake_ctl_q[PSC_WAKE_SIDL_BIT]);
  // one event per falling crossing, only while the sink discharges the pin
  assign wake_event = wake_active && wake_ctl_q[PSC_WAKE_SINK_BIT]
                    && pin_low_s && !pin_low_prev_q;

  // any wake cause while parked
  assign wake_any = irq_pending || irq_held_q || wdt_timeout || wake_event;

  // pad controls follow the module state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_sink_en <= 1'b0;
      wake_comp_en <= 1'b0;
    end else begin
      wake_sink_en <= wake_active && wake_ctl_q[PSC_WAKE_SINK_BIT];
      wake_comp_en <= wake_active;
    end
  end

  // power state sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      PSC_ST_RUN: begin
        if (power_save_req) begin
          state_d = PSC_ST_ENTER;
        end
      end
      PSC_ST_ENTER: begin
        state_d = power_save_sleep ? PSC_ST_SLEEP : PSC_ST_IDLE;
      end
      PSC_ST_SLEEP: begin
        if (wake_any) begin
          state_d = PSC_ST_RUN;
        end
      end
      PSC_ST_IDLE: begin
        if (wake_any) begin
          state_d = PSC_ST_RUN;
        end
      end
      default: begin
        state_d = PSC_ST_RUN;
      end
    endcase
  end

  // state register; reset always returns to run
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= PSC_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // interrupts seen during entry are parked until the mode is reached
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_held_q <= 1'b0;
    end else if (state_q == PSC_ST_ENTER || (state_q == PSC_ST_RUN && power_save_req)) begin
      irq_held_q <= irq_held_q || irq_pending;
    end else if (state_q != PSC_ST_RUN) begin
      irq_held_q <= irq_held_q;
    end else begin
      irq_held_q <= 1'b0;
    end
  end

  // interrupt reaches the CPU only in run, never mid-entry
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_to_cpu <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      irq_to_cpu <= irq_pending && state_q == PSC_ST_RUN && !power_save_req;
      wake_pulse <= (is_sleep || is_idle) && wake_any;
    end
  end

  // slowdown ratio: value n gives a period of two to the n cycles
  assign ratio = div_ctl_q[PSC_DIV_RATIO_MSB:PSC_DIV_RATIO_LSB];
  assign doze_limit = PSC_DOZE_CNT_W'((8'h01 << ratio) - 8'h01);
  assign doze_on = div_ctl_q[PSC_DIV_SLOW_EN_BIT];
  assign ret_int_clear = div_ctl_q[PSC_DIV_RET_INT_BIT] && doze_on && irq_pending;

  // doze counter runs off core_clk so the CPU enable stays in step with peripherals
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      doze_cnt_q <= '0;
    end else if (state_q != PSC_ST_RUN || !doze_on || doze_cnt_q >= doze_limit) begin
      doze_cnt_q <= '0;
    end else begin
      doze_cnt_q <= doze_cnt_q + PSC_DOZE_CNT_W'(1);
    end
  end

  // CPU clock enable: every cycle at full speed, one in 2^n in slowdown
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= (state_q == PSC_ST_RUN) && !power_save_req
                  && (!doze_on || ret_int_clear || doze_cnt_q == '0);
    end
  end

  // system clock stops only in Sleep; slowdown never touches it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sys_clk_en <= 1'b1;
      in_sleep <= 1'b0;
      in_idle <= 1'b0;
    end else begin
      sys_clk_en <= (state_d != PSC_ST_SLEEP);
      in_sleep <= (state_d == PSC_ST_SLEEP);
      in_idle <= (state_d == PSC_ST_IDLE);
    end
  end

  // per-peripheral gating; register access survives a cleared enable but not a disable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      periph_clk_en <= '1;
      periph_func_en <= '0;
      periph_reg_en <= '1;
    end else begin
      for (int i = 0; i < NUM_PERIPH; i++) begin
        periph_clk_en[i] <= (state_d != PSC_ST_SLEEP) && !mod_dis_q[i]
                          && !(state_d == PSC_ST_IDLE && mod_idl_q[i]);
        periph_func_en[i] <= mod_en_q[i] && !mod_dis_q[i]
                           && !(state_d == PSC_ST_IDLE && mod_idl_q[i]);
        periph_reg_en[i] <= !mod_dis_q[i];
      end
    end
  end

endmodule : psc_top
`default_nettype wire

// *** design/psc_pkg.sv ***
// Purpose: shared constants, types and register map of the power-save clock control block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: byte offsets below are the AHB byte addresses of each register
package psc_pkg;

  // register byte offsets
  localparam logic [7:0] PSC_OFS_WAKE_CONTROL = 8'h00;
  localparam logic [7:0] PSC_OFS_CLOCK_DIVIDER = 8'h04;
  localparam logic [7:0] PSC_OFS_FLAG_FIVE = 8'h08;
  localparam logic [7:0] PSC_OFS_MODULE_DISABLE = 8'h0C;
  localparam logic [7:0] PSC_OFS_MODULE_ENABLE = 8'h10;
  localparam logic [7:0] PSC_OFS_MODULE_IDLE_STOP = 8'h14;
  localparam logic [7:0] PSC_OFS_POWER_STATUS = 8'h18;

  // address decode window
  localparam int PSC_ADDR_W = 8;

  // wake_control fields
  localparam int PSC_WAKE_EN_BIT = 15;
  localparam int PSC_WAKE_SIDL_BIT = 13;
  localparam int PSC_WAKE_SINK_BIT = 8;
  localparam logic [15:0] PSC_WAKE_WR_MASK = 16'hA100;
  localparam logic [15:0] PSC_WAKE_RESET = 16'h0000;

  // clock_divider_reg fields
  localparam int PSC_DIV_RET_INT_BIT = 15;
  localparam int PSC_DIV_RATIO_MSB = 14;
  localparam int PSC_DIV_RATIO_LSB = 12;
  localparam int PSC_DIV_SLOW_EN_BIT = 11;
  localparam logic [15:0] PSC_DIV_WR_MASK = 16'hF800;
  localparam logic [15:0] PSC_DIV_RESET = 16'h0000;
  localparam int PSC_RATIO_W = 3;
  localparam int PSC_DOZE_CNT_W = 7;

  // interrupt_flag_reg_five fields
  localparam int PSC_FLAG_WAKE_BIT = 0;

  // power status fields
  localparam int PSC_STAT_SLEEP_BIT = 0;
  localparam int PSC_STAT_IDLE_BIT = 1;
  localparam int PSC_STAT_ENTER_BIT = 2;
  localparam int PSC_STAT_CPU_CLK_BIT = 3;

  // AHB encodings
  localparam logic [1:0] PSC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PSC_HTRANS_SEQ = 2'h3;
  localparam logic PSC_HRESP_OKAY = 1'h0;

  // power states
  typedef enum logic [1:0] {
    PSC_ST_RUN,
    PSC_ST_ENTER,
    PSC_ST_SLEEP,
    PSC_ST_IDLE
  } psc_state_t;

  // captured AHB address phase
  typedef struct packed {
    logic vld;
    logic wr;
    logic [PSC_ADDR_W-1:0] addr;
  } psc_ahb_cap_t;

endpackage : psc_pkg

// *** design/psc_sync2.sv ***
// Purpose: two-flop synchroniser for levels arriving from the pad comparator
// Assumes: input may change at any time relative to core_clk
// Notes: only the second stage is visible to the rest of the design
`timescale 1ns/100ps
`default_nettype none
module psc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds the second stage only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : psc_sync2
`default_nettype wire

// *** test/psc_top_asserts.sv ***
// Purpose: port-level timing checks of the power-save clock control block
// Assumes: one core_clk domain, nrst asynchronous and active low
// Notes: bound to every psc_top instance, sees only its ports
`timescale 1ns/100ps
`default_nettype none
module psc_top_asserts #(
  parameter int NUM_PERIPH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // cpu side
  input wire logic power_save_req,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  input wire logic irq_to_cpu,
  input wire logic wake_pulse,
  input wire logic cpu_clk_en,
  input wire logic in_sleep,
  input wire logic in_idle,
  // clocks and wake pad
  input wire logic sys_clk_en,
  input wire logic [NUM_PERIPH-1:0] periph_clk_en,
  input wire logic [NUM_PERIPH-1:0] periph_func_en,
  input wire logic [NUM_PERIPH-1:0] periph_reg_en,
  input wire logic wake_pin_low,
  input wire logic wake_sink_en,
  input wire logic wake_comp_en
);
  import psc_pkg::*;
  logic [7:0] gap_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // cycles in run without a cpu clock; the slowest ratio leaves 127 of them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_q <= 8'h00;
    end else if (cpu_clk_en || in_sleep || in_idle) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end

  a_bus_always_ok: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or gave an error");
  a_sleep_sysclk: assert property (sys_clk_en != in_sleep)
    else $error("system clock enable disagrees with sleep");
  a_halt_cpu_off: assert property ((in_sleep || in_idle) |-> !cpu_clk_en)
    else $error("cpu clock runs while halted");
  a_enter_two_edges: assert property (power_save_req && cpu_clk_en
    && !in_sleep && !in_idle |=> !cpu_clk_en ##1 (in_sleep || in_idle))
    else $error("power-save entry took the wrong number of edges");
  a_entry_irq_held: assert property (power_save_req && irq_pending && cpu_clk_en
    && !in_sleep && !in_idle |-> ##[2:5] wake_pulse)
    else $error("interrupt during entry did not wake the core");
  a_entry_no_irq: assert property (power_save_req |=> !irq_to_cpu)
    else $error("interrupt passed on during entry");
  // a running cpu clock means run state, so a pending interrupt must pass
  a_irq_passes: assert property (irq_pending && cpu_clk_en
    && !power_save_req |=> irq_to_cpu)
    else $error("interrupt not passed on in run");
  a_wake_on_cause: assert property ((in_sleep || in_idle)
    && (irq_pending || wdt_timeout) |=> wake_pulse && !in_sleep && !in_idle)
    else $error("wake cause did not end the halt");
  a_pin_wakes: assert property (in_sleep && wake_comp_en && wake_sink_en
    && $rose(wake_pin_low) |-> ##[1:5] wake_pulse)
    else $error("wake pin crossing did not end sleep");
  a_gate_order: assert property ((periph_func_en & ~periph_reg_en) == '0
    && (periph_clk_en & ~periph_reg_en) == '0)
    else $error("disabled peripheral still clocked or enabled");
  a_sleep_gates: assert property (in_sleep [*3] |-> periph_clk_en == '0)
    else $error("peripheral clock runs in sleep");
  a_slow_bounded: assert property (gap_q <= 8'h80)
    else $error("cpu clock gap longer than the slowest ratio");
endmodule : psc_top_asserts

bind psc_top psc_top_asserts #(.NUM_PERIPH(NUM_PERIPH)) i_psc_top_asserts (
  .core_clk, .nrst, .hreadyout, .hresp, .power_save_req, .irq_pending, .wdt_timeout,
  .irq_to_cpu, .wake_pulse, .cpu_clk_en, .in_sleep, .in_idle, .sys_clk_en, .periph_clk_en,
  .periph_func_en, .periph_reg_en, .wake_pin_low, .wake_sink_en, .wake_comp_en
);
`default_nettype wire

// *** test/psc_cpu_model.sv ***
// Purpose: behavioural cpu core issuing power-save requests, interrupts and time-outs
// Assumes: signals change right after a rising edge
// Notes: an interrupt is held until the core sees it taken or the device awake
`timescale 1ns/100ps
`default_nettype none
module psc_cpu_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // from the block
  input wire logic irq_to_cpu,
  input wire logic wake_pulse,
  input wire logic in_sleep,
  input wire logic in_idle,
  // to the block
  output logic power_save_req,
  output logic power_save_sleep,
  output logic irq_pending,
  output logic wdt_timeout
);
  // idle core at time zero
  initial begin
    power_save_req = 1'b0;
    power_save_sleep = 1'b0;
    irq_pending = 1'b0;
    wdt_timeout = 1'b0;
  end

  // one-cycle request; mode level kept until the next request
  task automatic enter(input logic slp, input logic irq, output logic seen);
    int n;
    @(posedge core_clk);
    power_save_req <= 1'b1;
    power_save_sleep <= slp;
    irq_pending <= irq;
    @(posedge core_clk);
    power_save_req <= 1'b0;
    seen = 1'b0;
    for (n = 0; n < 6 && !seen; n++) begin
      @(posedge core_clk);
      seen = in_sleep | in_idle;
    end
    for (n = 0; n < 6 && irq && !wake_pulse; n++) @(posedge core_clk);
    irq_pending <= 1'b0;
  endtask : enter

  // a late answer is as legal as a prompt one, so the delay is the caller's
  task automatic irq_hold(input int dly);
    int n;
    repeat (dly + 1) @(posedge core_clk);
    irq_pending <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(wake_pulse || irq_to_cpu) && n < 20);
    irq_pending <= 1'b0;
  endtask : irq_hold

  // watchdog time-out as a single pulse
  task automatic wdt_pulse();
    @(posedge core_clk);
    wdt_timeout <= 1'b1;
    @(posedge core_clk);
    wdt_timeout <= 1'b0;
  endtask : wdt_pulse
endmodule : psc_cpu_model
`default_nettype wire

// *** test/power_save_clock_control_bench.sv ***
// Purpose: self-checking bench of the power-save clock control block
// Assumes: zero-wait AHB-Lite slave, single master in this bench
// Notes: expected values come from an integer register model indexed by byte offset
`timescale 1ns/100ps
`default_nettype none
module power_save_clock_control_bench;
  import psc_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic wake_pin_low = 1'b0;
  logic hreadyout, hresp, irq_to_cpu, wake_pulse, cpu_clk_en, in_sleep, in_idle, sys_clk_en;
  logic power_save_req, power_save_sleep, irq_pending, wdt_timeout, wake_sink_en, wake_comp_en;
  logic [31:0] hrdata;
  logic [7:0] periph_clk_en, periph_func_en, periph_reg_en;
  int err_total = 0;
  int n_checks = 0;
  int seed = 75;
  int mdl [0:31];

  always #5 core_clk = ~core_clk;

  psc_top #(.NUM_PERIPH(8)) i_psc_top (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .power_save_req,
    .power_save_sleep, .irq_pending, .wdt_timeout, .irq_to_cpu, .wake_pulse, .cpu_clk_en,
    .in_sleep, .in_idle, .sys_clk_en, .periph_clk_en, .periph_func_en, .periph_reg_en,
    .wake_pin_low, .wake_sink_en, .wake_comp_en);
  psc_cpu_model i_psc_cpu_model (.core_clk, .nrst, .irq_to_cpu, .wake_pulse, .in_sleep,
    .in_idle, .power_save_req, .power_save_sleep, .irq_pending, .wdt_timeout);

  task automatic check(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check

  // single transfer: address phase, then data phase, each held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= PSC_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // writable bits of each slot; everything else reads zero
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
    case (a)
      8'h00: mdl[a] = v & 32'hA100;
      8'h04: mdl[a] = v & 32'hF800;
      8'h08: mdl[a] = v & 32'h1;
      8'h0C, 8'h10, 8'h14: mdl[a] = v & 32'hFF;
      default: mdl[a] = 0;
    endcase
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(e, d);
  endtask : rdc

  // md: 0 run, 1 sleep, 2 idle
  task automatic pchk(input int md);
    int st;
    int ck;
    repeat (2) @(negedge core_clk);
    st = (md == 2) ? mdl[20] : 0;
    ck = (md == 1) ? 0 : ~mdl[12] & ~st & 32'hFF;
    check(ck, {24'h0, periph_clk_en});
    check(mdl[16] & ~mdl[12] & ~st & 32'hFF, {24'h0, periph_func_en});
    check(~mdl[12] & 32'hFF, {24'h0, periph_reg_en});
  endtask : pchk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    logic s;
    int i, j, k;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    // reset values, the status word and one unmapped slot
    for (i = 0; i < 32; i += 4) rdc(i[7:0], (i == 24) ? 32'h8 : 32'h0);
    // random words keep only implemented bits
    for (i = 0; i < 24; i += 4) begin
      wr(i[7:0], $random(seed));
      rdc(i[7:0], mdl[i]);
    end
    pchk(0);
    // every ratio: cpu enable high once per 2^n cycles
    for (i = 0; i < 8; i++) begin
      wr(8'h04, 32'h0800 | (i << 12));
      rdc(8'h04, mdl[4]);
      k = 0;
      repeat (4 << i) begin
        @(negedge core_clk);
        k += cpu_clk_en;
      end
      check(32'h4, k);
      check(32'h1, {31'h0, sys_clk_en});
    end
    pchk(0);
    // interrupts end slowdown only with return-on-interrupt set
    for (i = 0; i < 2; i++) begin
      wr(8'h04, (i << 15) | 32'h3800);
      i_psc_cpu_model.irq_hold(i * 3);
      if (i == 1) mdl[4] = 32'hB000;
      rdc(8'h04, mdl[4]);
    end
    wr(8'h04, 32'h0);
    // both modes, woken by an interrupt or a watchdog time-out
    for (i = 0; i < 4; i++) begin
      i_psc_cpu_model.enter(i[0], 1'b0, s);
      check(32'h1, {31'h0, s});
      repeat (5) @(negedge core_clk);
      check({31'h0, i[0]}, {31'h0, ~sys_clk_en});
      pchk(2 - i[0]);
      // status word: sleep is bit 0, idle bit 1, cpu clock stopped
      rdc(8'h18, i[0] ? 32'h1 : 32'h2);
      if (i[1]) i_psc_cpu_model.wdt_pulse();
      else i_psc_cpu_model.irq_hold(i * 4);
      repeat (3) @(negedge core_clk);
      check(32'h0, {30'h0, in_sleep, in_idle});
    end
    // interrupt coinciding with the request: entry completes, then wake
    i_psc_cpu_model.enter(1'b1, 1'b1, s);
    check(32'h1, {31'h0, s});
    repeat (4) @(negedge core_clk);
    check(32'h0, {30'h0, in_sleep, in_idle});
    // wake module halted in idle only when stop-in-idle is set
    for (j = 0; j < 2; j++) begin
      wr(8'h00, (j == 1) ? 32'hA100 : 32'h8100);
      i_psc_cpu_model.enter(1'b0, 1'b0, s);
      repeat (2) @(negedge core_clk);
      check({31'h0, ~j[0]}, {31'h0, wake_comp_en});
      check({31'h0, ~j[0]}, {31'h0, wake_sink_en});
      i_psc_cpu_model.irq_hold(0);
    end
    // discharged pin wakes sleep and sets the flag once per crossing
    wr(8'h00, 32'h8100);
    wr(8'h08, 32'h0);
    i_psc_cpu_model.enter(1'b1, 1'b0, s);
    @(posedge core_clk);
    wake_pin_low <= 1'b1;
    k = 0;
    repeat (8) begin
      @(negedge core_clk);
      k += wake_pulse;
    end
    check(32'h1, k);
    rdc(8'h08, 32'h1);
    wr(8'h08, 32'h0);
    repeat (6) @(posedge core_clk);
    rdc(8'h08, 32'h0);
    wake_pin_low <= 1'b0;
    end_sim();
  end

  // hang guard, far beyond the under two thousand cycles the sequence needs
  initial begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    end_sim();
  end
endmodule : power_save_clock_control_bench
`default_nettype wire
